// file: common/bus_mode_pkg.sv
// Constants for the external bus mode configuration block
package bus_mode_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] GEOM_OFFSET = 8'h04;
  localparam logic [7:0] SEL_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] GEOM_RESET = 8'h00;
  localparam logic SEL_RESET = 1'b0;
  localparam logic [7:0] GEOM_MASK = 8'h0f;
  localparam int PORT_LSB = 0;
  localparam int STATIC_LSB = 2;
  localparam int SHARED_LSB = 4;
  localparam int WIDTH_LSB = 6;
  localparam int COL_LSB = 0;
  localparam int ROW_BIT = 2;
  localparam int CAS_BIT = 3;
  localparam logic [1:0] PORTS_OFF = 2'h0;
  localparam logic [1:0] PORTS_3 = 2'h1;
  localparam logic [1:0] PORTS_4 = 2'h2;
  localparam logic [1:0] PORTS_2 = 2'h3;
  localparam logic [1:0] MUX_ONE = 2'h0;
  localparam logic [1:0] MUX_TWO = 2'h1;
  localparam logic [1:0] MUX_BOTH = 2'h2;
  localparam logic [1:0] MUX_NONE = 2'h3;
  localparam logic [1:0] SHARE_ONE = 2'h0;
  localparam logic [1:0] SHARE_BOTH = 2'h2;
  localparam logic [1:0] WIDTH_NARROW = 2'h0;
  localparam logic [1:0] WIDTH_WIDE = 2'h1;
  localparam logic [3:0] MASK_2 = 4'h3;
  localparam logic [3:0] MASK_3 = 4'h7;
  localparam logic [3:0] MASK_4 = 4'hf;
  localparam logic [3:0] DATA_BITS_NARROW = 4'h4;
  localparam logic [3:0] DATA_BITS_WIDE = 4'h8;
  localparam logic [1:0] LATENCY_SHORT = 2'h2;
  localparam logic [1:0] LATENCY_LONG = 2'h3;
  localparam logic [3:0] ROWS_SHORT = 4'hb;
  localparam logic [3:0] ROWS_LONG = 4'hc;
  localparam logic [3:0] COLS_BASE = 4'h8;
  localparam logic [3:0] SDRAM_CS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bus_mode_pkg

// file: src/mode_decode.sv
// Registered decoder from register contents to bus configuration
`timescale 1ns/10ps
`default_nettype none
module mode_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] ctrl,
  input wire logic [7:0] geom,
  input wire logic sdram_req,
  output logic bus_enable,
  output logic [3:0] port_override,
  output logic latch_one_en,
  output logic latch_two_en,
  output logic no_latch_en,
  output logic static_ok,
  output logic shared_both,
  output logic shared_ok,
  output logic [3:0] data_bits,
  output logic width_ok,
  output logic sdram_active,
  output logic [3:0] sdram_cs_mask,
  output logic [1:0] read_latency,
  output logic [3:0] row_bits,
  output logic [3:0] col_bits
);
  logic [1:0] port_sel;
  logic [1:0] mux_sel;
  logic [1:0] share_sel;
  logic [1:0] width_sel;
  logic on;
  logic four;
  logic mux_ok;
  logic w_ok;
  assign port_sel = ctrl[bus_mode_pkg::PORT_LSB +: 2];
  assign mux_sel = ctrl[bus_mode_pkg::STATIC_LSB +: 2];
  assign share_sel = ctrl[bus_mode_pkg::SHARED_LSB +: 2];
  assign width_sel = ctrl[bus_mode_pkg::WIDTH_LSB +: 2];
  assign on = port_sel != bus_mode_pkg::PORTS_OFF;
  assign four = port_sel == bus_mode_pkg::PORTS_4;
  assign mux_ok = on && (four || mux_sel == bus_mode_pkg::MUX_ONE ||
                         mux_sel == bus_mode_pkg::MUX_BOTH);
  assign w_ok = width_sel == bus_mode_pkg::WIDTH_NARROW ||
                (width_sel == bus_mode_pkg::WIDTH_WIDE && four);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_enable <= 1'b0;
      port_override <= 4'h0;
    end else begin
      bus_enable <= on;
      case (port_sel)
        bus_mode_pkg::PORTS_3: port_override <= bus_mode_pkg::MASK_3;
        bus_mode_pkg::PORTS_4: port_override <= bus_mode_pkg::MASK_4;
        bus_mode_pkg::PORTS_2: port_override <= bus_mode_pkg::MASK_2;
        default: port_override <= 4'h0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_one_en <= 1'b0;
      latch_two_en <= 1'b0;
      no_latch_en <= 1'b0;
      static_ok <= 1'b0;
    end else begin
      static_ok <= mux_ok;
      latch_one_en <= mux_ok && (mux_sel == bus_mode_pkg::MUX_ONE ||
                                 mux_sel == bus_mode_pkg::MUX_BOTH);
      latch_two_en <= mux_ok && (mux_sel == bus_mode_pkg::MUX_TWO ||
                                 mux_sel == bus_mode_pkg::MUX_BOTH);
      no_latch_en <= mux_ok && mux_sel == bus_mode_pkg::MUX_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_both <= 1'b0;
      shared_ok <= 1'b0;
    end else begin
      shared_ok <= on && (share_sel == bus_mode_pkg::SHARE_ONE ||
                          share_sel == bus_mode_pkg::SHARE_BOTH);
      shared_both <= on && share_sel == bus_mode_pkg::SHARE_BOTH;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_bits <= bus_mode_pkg::DATA_BITS_NARROW;
      width_ok <= 1'b1;
      sdram_active <= 1'b0;
      sdram_cs_mask <= 4'h0;
    end else begin
      width_ok <= w_ok;
      data_bits <= (w_ok && width_sel == bus_mode_pkg::WIDTH_WIDE) ?
                   bus_mode_pkg::DATA_BITS_WIDE :
                   bus_mode_pkg::DATA_BITS_NARROW;
      sdram_active <= sdram_req && w_ok &&
                      (four || port_sel == bus_mode_pkg::PORTS_3);
      sdram_cs_mask <= (sdram_req && w_ok &&
                        (four || port_sel == bus_mode_pkg::PORTS_3)) ?
                       bus_mode_pkg::SDRAM_CS : 4'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_latency <= bus_mode_pkg::LATENCY_SHORT;
      row_bits <= bus_mode_pkg::ROWS_SHORT;
      col_bits <= bus_mode_pkg::COLS_BASE;
    end else begin
      read_latency <= geom[bus_mode_pkg::CAS_BIT] ?
                      bus_mode_pkg::LATENCY_LONG :
                      bus_mode_pkg::LATENCY_SHORT;
      row_bits <= geom[bus_mode_pkg::ROW_BIT] ?
                  bus_mode_pkg::ROWS_LONG : bus_mode_pkg::ROWS_SHORT;
      col_bits <= bus_mode_pkg::COLS_BASE +
                  {2'h0, geom[bus_mode_pkg::COL_LSB +: 2]};
    end
  end
endmodule : mode_decode
`default_nettype wire

// file: src/bus_mode_config.sv
// Register file and bus slave of the external bus mode configuration
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module bus_mode_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic bus_enable,
  output logic [3:0] port_override,
  output logic latch_strobe_one_en,
  output logic latch_strobe_two_en,
  output logic no_latch_option_en,
  output logic shared_data_both,
  output logic [3:0] sdram_data_bits,
  output logic sdram_active,
  output logic [3:0] sdram_cs_mask,
  output logic [1:0] read_latency,
  output logic [3:0] row_addr_bits,
  output logic [3:0] col_addr_bits
);
  logic [7:0] ctrl_reg;
  logic [7:0] geom_reg;
  logic sel_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic do_write;
  logic static_ok;
  logic shared_ok;
  logic width_ok;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == bus_mode_pkg::CTRL_OFFSET ||
             a == bus_mode_pkg::GEOM_OFFSET ||
             a == bus_mode_pkg::SEL_OFFSET ||
             a == bus_mode_pkg::STATUS_OFFSET;
  endfunction : mapped

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == bus_mode_pkg::CTRL_OFFSET) begin
      v = ctrl_reg;
    end else if (a == bus_mode_pkg::GEOM_OFFSET) begin
      v = geom_reg & bus_mode_pkg::GEOM_MASK;
    end else if (a == bus_mode_pkg::SEL_OFFSET) begin
      v = {7'h00, sel_reg};
    end else if (a == bus_mode_pkg::STATUS_OFFSET) begin
      v = {4'h0, sdram_active, width_ok, shared_ok, static_ok};
    end
    read_word = {24'h000000, v};
  endfunction : read_word

  // Write address and data are taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_hold_reg <= 1'b0;
      waddr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_hold_reg <= 1'b1;
      waddr_reg <= awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end else if (!aw_hold_reg && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb0_reg <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_hold_reg <= 1'b1;
      wdata_reg <= wdata;
      wstrb0_reg <= wstrb[0];
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end else if (!w_hold_reg && !bvalid) begin
      wready <= 1'b1;
    end
  end

  assign do_write = aw_hold_reg && w_hold_reg && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= bus_mode_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= mapped(waddr_reg) ? bus_mode_pkg::RESP_OKAY :
               bus_mode_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 holds register bits; other lanes are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= bus_mode_pkg::CTRL_RESET;
      geom_reg <= bus_mode_pkg::GEOM_RESET;
      sel_reg <= bus_mode_pkg::SEL_RESET;
    end else if (do_write && wstrb0_reg) begin
      if (waddr_reg == bus_mode_pkg::CTRL_OFFSET) begin
        ctrl_reg <= wdata_reg[7:0];
      end else if (waddr_reg == bus_mode_pkg::GEOM_OFFSET) begin
        geom_reg <= wdata_reg[7:0] & bus_mode_pkg::GEOM_MASK;
      end else if (waddr_reg == bus_mode_pkg::SEL_OFFSET) begin
        sel_reg <= wdata_reg[0];
      end
    end
  end

  // Read data is captured on the address edge, valid one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= bus_mode_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= read_word(araddr);
      rresp <= mapped(araddr) ? bus_mode_pkg::RESP_OKAY :
               bus_mode_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Illegal combinations are decoded to safe outputs, not refused
  mode_decode u_decode (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(ctrl_reg),
    .geom(geom_reg),
    .sdram_req(sel_reg),
    .bus_enable(bus_enable),
    .port_override(port_override),
    .latch_one_en(latch_strobe_one_en),
    .latch_two_en(latch_strobe_two_en),
    .no_latch_en(no_latch_option_en),
    .static_ok(static_ok),
    .shared_both(shared_data_both),
    .shared_ok(shared_ok),
    .data_bits(sdram_data_bits),
    .width_ok(width_ok),
    .sdram_active(sdram_active),
    .sdram_cs_mask(sdram_cs_mask),
    .read_latency(read_latency),
    .row_bits(row_addr_bits),
    .col_bits(col_addr_bits)
  );

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_port_off;
    (ctrl_reg[1:0] == bus_mode_pkg::PORTS_OFF) |=>
      (!bus_enable && port_override == 4'h0);
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("port override active while bus off");

  property p_port_three;
    (ctrl_reg[1:0] == bus_mode_pkg::PORTS_3) |=>
      (bus_enable && port_override == 4'h7);
  endproperty
  a_port_three: assert property (p_port_three)
    else $error("three port setting gives wrong override");

  sequence s_both_strobes;
    ctrl_reg[1:0] != bus_mode_pkg::PORTS_OFF &&
      ctrl_reg[3:2] == bus_mode_pkg::MUX_BOTH;
  endsequence
  property p_both_strobes;
    s_both_strobes |=>
      (latch_strobe_one_en && latch_strobe_two_en && !no_latch_option_en);
  endproperty
  a_both_strobes: assert property (p_both_strobes)
    else $error("three byte sharing lacks a strobe");

  property p_narrow_limits;
    (ctrl_reg[1:0] != bus_mode_pkg::PORTS_4 &&
     (ctrl_reg[3:2] == bus_mode_pkg::MUX_TWO ||
      ctrl_reg[3:2] == bus_mode_pkg::MUX_NONE)) |=>
      (!static_ok && !latch_strobe_two_en && !no_latch_option_en);
  endproperty
  a_narrow_limits: assert property (p_narrow_limits)
    else $error("four port static mode offered on narrow bus");

  property p_shared_reserved;
    ctrl_reg[4] |=> !shared_ok;
  endproperty
  a_shared_reserved: assert property (p_shared_reserved)
    else $error("reserved shared data code accepted");

  property p_width_narrow;
    (ctrl_reg[7:6] == bus_mode_pkg::WIDTH_NARROW) |=>
      (sdram_data_bits == 4'h4 && width_ok);
  endproperty
  a_width_narrow: assert property (p_width_narrow)
    else $error("narrow width code not four bits");

  property p_wide_four_port;
    (sdram_data_bits == 4'h8) |->
      ($past(ctrl_reg[1:0]) == bus_mode_pkg::PORTS_4);
  endproperty
  a_wide_four_port: assert property (p_wide_four_port)
    else $error("eight bit bus without four ports");

  sequence s_geom_read;
    arvalid && arready && araddr == bus_mode_pkg::GEOM_OFFSET;
  endsequence
  property p_geom_upper_zero;
    s_geom_read |=> (rvalid && rdata[7:4] == 4'h0);
  endproperty
  a_geom_upper_zero: assert property (p_geom_upper_zero)
    else $error("geometry reserved bits read nonzero");

  property p_latency;
    $stable(geom_reg[3]) |=>
      (read_latency == ($past(geom_reg[3]) ? 2'h3 : 2'h2));
  endproperty
  a_latency: assert property (p_latency)
    else $error("read latency does not follow its bit");

  property p_rows;
    1'b1 |=> (row_addr_bits == ($past(geom_reg[2]) ? 4'hc : 4'hb));
  endproperty
  a_rows: assert property (p_rows)
    else $error("row count does not follow its bit");

  property p_cols;
    (geom_reg[1:0] == 2'h3) [*2] |-> (col_addr_bits == 4'hb);
  endproperty
  a_cols: assert property (p_cols)
    else $error("top column code not eleven bits");

  property p_cs_fourth;
    (sdram_cs_mask != 4'h0) |->
      (sdram_cs_mask == 4'h8 && sdram_active &&
       ($past(ctrl_reg[1:0]) == bus_mode_pkg::PORTS_3 ||
        $past(ctrl_reg[1:0]) == bus_mode_pkg::PORTS_4));
  endproperty
  a_cs_fourth: assert property (p_cs_fourth)
    else $error("dynamic memory select misplaced");

  property p_no_latch_four;
    (ctrl_reg[1:0] == bus_mode_pkg::PORTS_4 &&
     ctrl_reg[3:2] == bus_mode_pkg::MUX_NONE) |=>
      (no_latch_option_en && !latch_strobe_one_en && !latch_strobe_two_en);
  endproperty
  a_no_latch_four: assert property (p_no_latch_four)
    else $error("unmultiplexed mode still drives a strobe");

  property p_shared_both;
    (ctrl_reg[1:0] != bus_mode_pkg::PORTS_OFF &&
     ctrl_reg[5:4] == bus_mode_pkg::SHARE_BOTH) |=> shared_data_both;
  endproperty
  a_shared_both: assert property (p_shared_both)
    else $error("two byte data sharing not selected");

  property p_width_wide;
    (ctrl_reg[1:0] == bus_mode_pkg::PORTS_4 &&
     ctrl_reg[7:6] == bus_mode_pkg::WIDTH_WIDE) |=>
      (sdram_data_bits == 4'h8 && width_ok);
  endproperty
  a_width_wide: assert property (p_width_wide)
    else $error("wide code on four ports not eight bits");

  property p_read_answer;
    (arvalid && arready) |=> (rvalid && !arready);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data not raised after address");

  property p_write_answer;
    do_write |=> (bvalid && !awready && !wready);
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response not raised after both parts");
endmodule : bus_mode_config
`default_nettype wire

// file: tb/ext_mem_model.sv
// Far-side memory and latch model that watches the bus configuration
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  input wire logic aclk,
  input wire logic bus_enable,
  input wire logic latch_strobe_one_en,
  input wire logic latch_strobe_two_en,
  input wire logic no_latch_option_en,
  input wire logic sdram_active,
  input wire logic [3:0] sdram_cs_mask,
  input wire logic [3:0] port_override,
  output logic [1:0] latch_count,
  output logic conflict
);
  // one external latch per strobe in use
  assign latch_count = {1'b0, latch_strobe_one_en} +
    {1'b0, latch_strobe_two_en};
  // dynamic memory hangs on the fourth select only
  // latches cannot run on a bus that is off
  always_ff @(posedge aclk) begin
    conflict <= (sdram_active && sdram_cs_mask !== 4'h8) ||
      (!bus_enable && (latch_count != 2'h0 || no_latch_option_en)) ||
      (sdram_active && port_override[3:2] == 2'h0);
  end
endmodule : ext_mem_model
`default_nettype wire

// file: tb/external_bus_mode_config_bench.sv
// Register-level bench of the external bus mode configuration
`timescale 1ns/10ps
`default_nettype none
module external_bus_mode_config_bench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_lat, lcnt, r;
  logic [31:0] rdata, d;
  logic bus_en, l1, l2, nl, shb, sda, conflict;
  logic [3:0] povr, dbits, csm, rows, cols;
  int fails = 0, check_count = 0;
  always #12.5 aclk = ~aclk;
  bus_mode_config dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bus_enable(bus_en), .port_override(povr),
    .latch_strobe_one_en(l1), .latch_strobe_two_en(l2),
    .no_latch_option_en(nl), .shared_data_both(shb),
    .sdram_data_bits(dbits), .sdram_active(sda), .sdram_cs_mask(csm),
    .read_latency(rd_lat), .row_addr_bits(rows), .col_addr_bits(cols));
  ext_mem_model mem_u (.aclk(aclk), .bus_enable(bus_en),
    .latch_strobe_one_en(l1), .latch_strobe_two_en(l2),
    .no_latch_option_en(nl), .sdram_active(sda), .sdram_cs_mask(csm),
    .port_override(povr), .latch_count(lcnt), .conflict(conflict));
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: response %h expected %h", $time, got, exp);
    end
  endtask : check_resp
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Waits are unbounded; the watchdog catches a missing answer
  task axi_write(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write
  task axi_read(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read
  task wr(input logic [7:0] a, input logic [31:0] v);
    axi_write(a, v, r);
    check_resp(r, bus_mode_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask : wr
  task set_ctrl(input logic [1:0] w, s, m, p);
    wr(bus_mode_pkg::CTRL_OFFSET, {24'h0, w, s, m, p});
  endtask : set_ctrl
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_read(bus_mode_pkg::CTRL_OFFSET, d, r);
    check_val(d, 32'h0);
    axi_read(bus_mode_pkg::GEOM_OFFSET, d, r);
    check_val(d, 32'h0);
    check_val({rd_lat, rows, cols, dbits}, {2'h2, 4'hb, 4'h8, 4'h4});
    check_val({bus_en, povr}, 5'h00);
    // Each port code and the mask of ports taken over
    for (int p = 0; p < 4; p++) begin
      set_ctrl(2'h0, 2'h3, 2'h0, p[1:0]);
      check_val({bus_en, povr}, p == 0 ? 5'h00 : p == 1 ? 5'h17 :
        p == 2 ? 5'h1f : 5'h13);
    end
    // Static codes on four ports, then on three where two are refused
    for (int m = 0; m < 4; m++) begin
      set_ctrl(2'h0, 2'h0, m[1:0], bus_mode_pkg::PORTS_4);
      check_val({l1, l2, nl}, {m == 0 || m == 2, m == 1 || m == 2,
        m == 3});
      check_val(conflict, 1'b0);
      check_val(lcnt, m == 2 ? 2 : m == 3 ? 0 : 1);
      set_ctrl(2'h0, 2'h0, m[1:0], bus_mode_pkg::PORTS_3);
      check_val({l1, l2, nl}, {m == 0 || m == 2, m == 2, 1'b0});
    end
    set_ctrl(2'h0, 2'h0, 2'h0, bus_mode_pkg::PORTS_OFF);
    check_val({l1, l2, nl}, 3'h0);
    // Shared data codes, reserved ones decode to off
    for (int s = 0; s < 4; s++) begin
      set_ctrl(2'h0, s[1:0], 2'h0, bus_mode_pkg::PORTS_4);
      check_val(shb, s == 2);
      axi_read(bus_mode_pkg::STATUS_OFFSET, d, r);
      check_val(d[1], s == 0 || s == 2);
    end
    // Width codes on four ports and on three
    for (int w = 0; w < 4; w++) begin
      set_ctrl(w[1:0], 2'h0, 2'h0, bus_mode_pkg::PORTS_4);
      check_val(dbits, w == 1 ? 4'h8 : 4'h4);
      axi_read(bus_mode_pkg::STATUS_OFFSET, d, r);
      check_val(d[2], w < 2);
      set_ctrl(w[1:0], 2'h0, 2'h0, bus_mode_pkg::PORTS_3);
      check_val(dbits, 4'h4);
    end
    // Geometry: reserved top bits, latency, rows, columns
    wr(bus_mode_pkg::GEOM_OFFSET, 32'h000000ff);
    axi_read(bus_mode_pkg::GEOM_OFFSET, d, r);
    check_val(d, 32'h0000000f);
    check_val({rd_lat, rows}, {2'h3, 4'hc});
    for (int c = 0; c < 4; c++) begin
      wr(bus_mode_pkg::GEOM_OFFSET, {30'h0, c[1:0]});
      check_val(cols, 4'h8 + c[3:0]);
      check_val({rd_lat, rows}, {2'h2, 4'hb});
    end
    // Dynamic memory select against each port setting
    wr(bus_mode_pkg::SEL_OFFSET, 32'h1);
    for (int p = 0; p < 4; p++) begin
      set_ctrl(2'h0, 2'h0, 2'h0, p[1:0]);
      check_val({sda, csm}, (p == 1 || p == 2) ? 5'h18 : 5'h00);
      check_val(conflict, 1'b0);
    end
    // Unmapped place refuses and reads zero
    axi_write(8'h10, 32'h5a, r);
    check_resp(r, bus_mode_pkg::RESP_SLVERR);
    axi_read(8'h10, d, r);
    check_resp(r, bus_mode_pkg::RESP_SLVERR);
    check_val(d, 32'h0);
    tally_and_finish();
  end
  // Whole run is a few hundred cycles; allow ample margin
  initial begin
    #(25 * 20000);
    fails++;
    tally_and_finish();
  end
endmodule : external_bus_mode_config_bench
`default_nettype wire
